/* File: pkg/vram_access_consts.vh */
`ifndef VRAM_ACCESS_CONSTS_VH
`define VRAM_ACCESS_CONSTS_VH

// ****************************************
// register map (byte addresses)
// ****************************************
`define REG_CTRL_OFS     4'h0
`define REG_STAT_OFS     4'h4
`define REG_FETCH_OFS    4'h8

// control fields
`define CTRL_GRAPH_BIT   0
`define CTRL_REFEN_BIT   1
`define CTRL_RESET_VAL   2'h2

// status fields
`define STAT_LCD_BIT     0
`define STAT_FONT_BIT    1
`define STAT_PEND_BIT    2
`define STAT_DOUBLE_BIT  3
`define STAT_STATE_LSB   4

// attribute bit steering the font
`define ATTR_INTENS_BIT  3

// ****************************************
// timing
// ****************************************
// cycles a memory slot lasts: address cycle, then strobe cycle
`define SLOT_CYCLES      2'h2

// axi response codes
`define AXI_RESP_OKAY    2'h0
`define AXI_RESP_SLVERR  2'h2

`endif

/* File: rtl/video_ram_and_font_access.v */
// Decided for this implementation: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/10ps
`include "vram_access_consts.vh"
// Operation
// - low five vram address lines driven direct; upper eight via external mux
// - host read/write slots and controller refresh fetches share the vram
// - chip enable low-active; only the low chip enable is ever asserted
// - even byte on character bus, odd byte on attribute bus
// - refresh fetch enables both srams and captures both bytes together
// - host read enables both, returns char byte if bit0 low, else attr
// - vram write only while memory select and memory write both low
// - write steers strobe and data to char or attr bus by bit0
// - strobes act as sram write enables, pulsed in a host write slot whether bit 14 puts chip enable low or high
// - host address bits 1..13 to sram address, bit 14 to chip enable
// - refresh: text uses address 0..13; graphics puts raster 0/1 on top
// - four raster bits carried; only two low bits address graphics memory
// - refresh address select low for refresh, high for host address
// - latch strobe rising edge captures fetched character code
// - font address completed by plasma, dot style and four raster outputs
// - dot style low selects single font, high double font
// - eight shared video outputs for lcd and crt
// - lcd double when attr bit3 differs from font change; crt follows input
// - host access only while display memory select is low
// - ready held low while a host vram access waits
module video_ram_and_font_access (
	// clock and reset
	input  wire        clock,
	input  wire        rst,
	// host i/o bus
	input  wire        display_mem_select_n,
	input  wire        host_mem_select_n,
	input  wire        host_mem_write_n,
	input  wire        host_mem_read_n,
	input  wire        host_addr_bit0,
	input  wire [4:0]  host_addr_low,
	input  wire        host_addr_bit14,
	input  wire [7:0]  host_data_in,
	output reg  [7:0]  host_data_out,
	output wire        host_data_oe,
	output wire        host_ready_out,
	// video ram
	output reg  [4:0]  vram_low_addr,
	output reg  [7:0]  refresh_upper_addr,
	output reg         refresh_addr_sel,
	output reg         vram_chip_enable_lo,
	output wire        vram_chip_enable_hi,
	output reg         char_write_strobe,
	output reg         attr_write_strobe,
	input  wire [7:0]  char_data_in,
	output reg  [7:0]  char_data_out,
	output reg         char_data_oe,
	input  wire [7:0]  attr_data_in,
	output reg  [7:0]  attr_data_out,
	output reg         attr_data_oe,
	// timing generator side
	input  wire        refresh_req,
	input  wire [13:0] refresh_mem_addr,
	input  wire [3:0]  raster_scan_in,
	input  wire [8:0]  timing_video_in,
	// font rom addressing
	output reg         font_code_latch,
	output wire        plasma_font_sel,
	output reg         dot_style_sel,
	output reg  [3:0]  raster_line_addr,
	// display mode
	input  wire        font_change_in,
	input  wire        display_select_in,
	input  wire        panel_type_in,
	input  wire        crt_video_clock,
	// shared video outputs
	output reg         line_pulse,
	output reg         frame_pulse,
	output reg         frame_sig,
	output reg  [3:0]  video_data,
	output reg         shift_clock,
	// axi4-lite slave
	input  wire [3:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output wire        s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output wire        s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [3:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output wire        s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready
);

	// ****************************************
	// slot sequencer states
	// ****************************************
	localparam [1:0] ST_IDLE = 2'h0;
	localparam [1:0] ST_REF  = 2'h1;
	localparam [1:0] ST_HOST = 2'h2;
	localparam [1:0] ST_DONE = 2'h3;

	reg  [1:0] state_q;
	reg  [1:0] state_d;
	reg  [1:0] cnt_q;
	reg        ref_pend_q;
	reg        host_wr_q;
	reg        host_odd_q;
	reg  [7:0] char_q;
	reg  [7:0] attr_q;
	reg  [1:0] ctrl_q;
	reg        aw_held_q;
	reg  [3:0] aw_addr_q;
	reg        w_held_q;
	reg  [31:0] w_data_q;
	reg  [3:0] w_strb_q;
	reg        crt_clk_q;

	wire       graph_mode = ctrl_q[`CTRL_GRAPH_BIT];
	wire       ref_enable = ctrl_q[`CTRL_REFEN_BIT];
	wire       slot_last  = (cnt_q == `SLOT_CYCLES - 2'h1);

	// ****************************************
	// host request decode
	// ****************************************
	// writes need both selects and the write strobe
	wire host_wr = ~display_mem_select_n & ~host_mem_select_n & ~host_mem_write_n;
	wire host_rd = ~display_mem_select_n & ~host_mem_read_n;
	wire host_req = host_wr | host_rd;

	// ready falls at once so the host never misses the wait
	assign host_ready_out = ~(host_req & (state_q != ST_DONE));
	assign host_data_oe = host_rd & (state_q == ST_DONE);
	assign vram_chip_enable_hi = 1'b1;
	assign plasma_font_sel = 1'b1;

	// ****************************************
	// refresh request capture
	// ****************************************
	// a new request in the same cycle as service wins
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			ref_pend_q <= 1'b0;
		end else if (refresh_req & ref_enable) begin
			ref_pend_q <= 1'b1;
		end else if (state_q == ST_REF && cnt_q == 2'h0) begin
			ref_pend_q <= 1'b0;
		end
	end

	// ****************************************
	// slot sequencer
	// ****************************************
	// next state: refresh always takes a free slot first
	always @* begin
		state_d = state_q;
		case (state_q)
			ST_IDLE: begin
				if (ref_pend_q) begin
					state_d = ST_REF;
				end else if (host_req) begin
					state_d = ST_HOST;
				end
			end
			ST_REF: state_d = slot_last ? ST_IDLE : ST_REF;
			ST_HOST: state_d = slot_last ? ST_DONE : ST_HOST;
			// hold until the host drops its strobe, so one request is served once
			ST_DONE: state_d = host_req ? ST_DONE : ST_IDLE;
			default: begin
				state_d = ST_IDLE;
			end
		endcase
	end

	// state register and slot cycle counter
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			state_q <= ST_IDLE;
			cnt_q   <= 2'h0;
		end else begin
			state_q <= state_d;
			if (state_d != state_q) begin
				cnt_q <= 2'h0;
			end else begin
				cnt_q <= cnt_q + 2'h1;
			end
		end
	end

	// ****************************************
	// vram address, enable and strobes
	// ****************************************
	// all memory pins but the tied-high chip enable registered so the srams see clean edges
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			vram_low_addr       <= 5'h00;
			refresh_upper_addr  <= 8'h00;
			refresh_addr_sel    <= 1'b0;
			vram_chip_enable_lo <= 1'b1;
			char_write_strobe   <= 1'b1;
			attr_write_strobe   <= 1'b1;
			char_data_out       <= 8'h00;
			attr_data_out       <= 8'h00;
			char_data_oe        <= 1'b0;
			attr_data_oe        <= 1'b0;
			host_wr_q           <= 1'b0;
			host_odd_q          <= 1'b0;
			font_code_latch     <= 1'b0;
		end else begin
			font_code_latch   <= 1'b0;
			char_write_strobe <= 1'b1;
			attr_write_strobe <= 1'b1;
			if (state_d == ST_REF && state_q != ST_REF) begin
				refresh_addr_sel <= 1'b0;
				vram_low_addr    <= refresh_mem_addr[4:0];
				if (graph_mode) begin
					// graphics: raster bit 0 on the top line, bit 1 on enable
					refresh_upper_addr  <= {raster_scan_in[0], refresh_mem_addr[11:5]};
					vram_chip_enable_lo <= raster_scan_in[1];
				end else begin
					refresh_upper_addr  <= refresh_mem_addr[12:5];
					vram_chip_enable_lo <= refresh_mem_addr[13];
				end
				char_data_oe <= 1'b0;
				attr_data_oe <= 1'b0;
			end else if (state_d == ST_HOST && state_q != ST_HOST) begin
				// upper lines come from the host bus through the mux
				refresh_addr_sel    <= 1'b1;
				vram_low_addr       <= host_addr_low;
				vram_chip_enable_lo <= host_addr_bit14;
				host_wr_q           <= host_wr;
				host_odd_q          <= host_addr_bit0;
				char_data_out       <= host_data_in;
				attr_data_out       <= host_data_in;
				char_data_oe        <= host_wr & ~host_addr_bit0;
				attr_data_oe        <= host_wr & host_addr_bit0;
			end else if (state_q == ST_REF && cnt_q == 2'h0) begin
				// data settled a cycle; the rising edge latches the code
				font_code_latch <= 1'b1;
			end else if (state_q == ST_HOST && cnt_q == 2'h0 && host_wr_q) begin
				// strobe only inside a host write slot, whatever bit 14 puts on the chip enable; address already stable
				char_write_strobe <= host_odd_q;
				attr_write_strobe <= ~host_odd_q;
			end else if (state_d == ST_IDLE || state_d == ST_DONE) begin
				vram_chip_enable_lo <= 1'b1;
				refresh_addr_sel    <= 1'b0;
				char_data_oe        <= 1'b0;
				attr_data_oe        <= 1'b0;
			end
		end
	end

	// ****************************************
	// read data capture
	// ****************************************
	// both bytes of a refresh arrive together; host gets one byte
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			char_q        <= 8'h00;
			attr_q        <= 8'h00;
			host_data_out <= 8'h00;
		end else if (state_q == ST_REF && slot_last) begin
			char_q <= char_data_in;
			attr_q <= attr_data_in;
		end else if (state_q == ST_HOST && slot_last && !host_wr_q) begin
			host_data_out <= host_odd_q ? attr_data_in : char_data_in;
		end
	end

	// ****************************************
	// font rom address extras
	// ****************************************
	// panel type is not looked at: board holds it for lcd
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			dot_style_sel    <= 1'b0;
			raster_line_addr <= 4'h0;
		end else begin
			raster_line_addr <= raster_scan_in;
			if (display_select_in) begin
				dot_style_sel <= attr_q[`ATTR_INTENS_BIT] ^ font_change_in;
			end else begin
				dot_style_sel <= font_change_in;
			end
		end
	end

	// ****************************************
	// shared video outputs
	// ****************************************
	// one register stage; lcd and crt meaning set by the display unit
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			line_pulse  <= 1'b0;
			frame_pulse <= 1'b0;
			frame_sig   <= 1'b0;
			video_data  <= 4'h0;
			shift_clock <= 1'b0;
			crt_clk_q   <= 1'b0;
		end else begin
			line_pulse  <= timing_video_in[0];
			frame_pulse <= timing_video_in[1];
			frame_sig   <= timing_video_in[2];
			video_data  <= timing_video_in[6:3];
			shift_clock <= timing_video_in[7] | timing_video_in[8];
			crt_clk_q   <= crt_video_clock;
		end
	end

	// ****************************************
	// axi4-lite write channel
	// ****************************************
	// address and data accepted in either order, one write at a time
	assign s_axi_awready = ~aw_held_q & ~s_axi_bvalid;
	assign s_axi_wready  = ~w_held_q & ~s_axi_bvalid;

	always @(posedge clock or posedge rst) begin
		if (rst) begin
			aw_held_q    <= 1'b0;
			aw_addr_q    <= 4'h0;
			w_held_q     <= 1'b0;
			w_data_q     <= 32'h00000000;
			w_strb_q     <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `AXI_RESP_OKAY;
			ctrl_q       <= `CTRL_RESET_VAL;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_q <= 1'b1;
				aw_addr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_q <= 1'b1;
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
			end
			if (aw_held_q && w_held_q && !s_axi_bvalid) begin
				aw_held_q    <= 1'b0;
				w_held_q     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				if (aw_addr_q == `REG_CTRL_OFS) begin
					s_axi_bresp <= `AXI_RESP_OKAY;
					if (w_strb_q[0]) begin
						ctrl_q <= w_data_q[1:0];
					end
				end else if (aw_addr_q == `REG_STAT_OFS || aw_addr_q == `REG_FETCH_OFS) begin
					// read-only registers ignore the data
					s_axi_bresp <= `AXI_RESP_OKAY;
				end else begin
					s_axi_bresp <= `AXI_RESP_SLVERR;
				end
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// ****************************************
	// axi4-lite read channel
	// ****************************************
	assign s_axi_arready = ~s_axi_rvalid;

	always @(posedge clock or posedge rst) begin
		if (rst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h00000000;
			s_axi_rresp  <= `AXI_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp  <= `AXI_RESP_OKAY;
			case (s_axi_araddr)
				`REG_CTRL_OFS: begin
					s_axi_rdata <= {30'h00000000, ctrl_q};
				end
				`REG_STAT_OFS: begin
					s_axi_rdata <= {24'h000000, 1'b0, crt_clk_q, state_q,
						dot_style_sel, ref_pend_q, font_change_in, display_select_in};
				end
				`REG_FETCH_OFS: begin
					s_axi_rdata <= {16'h0000, attr_q, char_q};
				end
				default: begin
					s_axi_rdata <= 32'h00000000;
					s_axi_rresp <= `AXI_RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

endmodule // video_ram_and_font_access

/* File: sim/host_bus_model.sv */
`timescale 1ns/10ps
// ****************************************
// host processor on the vram bus
// ****************************************
module host_bus_model (
	// clock
	input  wire       clock,
	// answer
	input  wire       host_ready_out,
	input  wire [7:0] host_data_out,
	// request lines
	output reg        display_mem_select_n,
	output reg        host_mem_select_n,
	output reg        host_mem_write_n,
	output reg        host_mem_read_n,
	output reg        host_addr_bit0,
	output reg  [4:0] host_addr_low,
	output reg        host_addr_bit14,
	output reg  [7:0] host_data_in
);
	// idle bus at time zero
	initial begin
		{display_mem_select_n, host_mem_select_n, host_mem_write_n, host_mem_read_n} = 4'hF;
		{host_addr_bit14, host_addr_low, host_addr_bit0, host_data_in} = 15'h0;
	end

	// one byte; request held until ready is sampled high, released data shows its inverse
	task access(input logic we, input logic [6:0] a, input logic [7:0] wd, output logic [7:0] rd);
		@(posedge clock);
		display_mem_select_n <= 1'h0;
		host_mem_select_n <= !we;
		host_mem_write_n <= !we;
		host_mem_read_n <= we;
		{host_addr_bit14, host_addr_low, host_addr_bit0} <= a;
		host_data_in <= we ? wd : ~wd;
		@(posedge clock);
		while (host_ready_out !== 1'h1) @(posedge clock);
		rd = host_data_out;
		{display_mem_select_n, host_mem_select_n, host_mem_write_n, host_mem_read_n} <= 4'hF;
		host_data_in <= ~host_data_in;
	endtask
endmodule // host_bus_model

/* File: sim/video_ram_and_font_access_checker.sv */
`timescale 1ns/10ps
// ****************************************
// vram access checker
// ****************************************
module video_ram_and_font_access_checker (
	// clock and reset
	input wire       clock,
	input wire       rst,
	// host bus
	input wire       display_mem_select_n,
	input wire       host_mem_select_n,
	input wire       host_mem_write_n,
	input wire       host_mem_read_n,
	input wire       host_addr_bit0,
	input wire [7:0] host_data_in,
	input wire [7:0] host_data_out,
	input wire       host_data_oe,
	input wire       host_ready_out,
	// video ram
	input wire       refresh_addr_sel,
	input wire       vram_chip_enable_lo,
	input wire       vram_chip_enable_hi,
	input wire       char_write_strobe,
	input wire       attr_write_strobe,
	input wire [7:0] char_data_in,
	input wire [7:0] char_data_out,
	input wire       char_data_oe,
	input wire [7:0] attr_data_in,
	input wire [7:0] attr_data_out,
	input wire       attr_data_oe,
	// font and video
	input wire       font_code_latch,
	input wire       plasma_font_sel,
	input wire [8:0] timing_video_in,
	input wire       line_pulse,
	input wire       frame_pulse,
	input wire       frame_sig,
	input wire [3:0] video_data,
	input wire       shift_clock
);
	// a host request as the controller must see it; reads need no memory select
	wire hreq = !display_mem_select_n && (!host_mem_read_n || (!host_mem_write_n && !host_mem_select_n));
	wire wstb = !char_write_strobe || !attr_write_strobe;

	default clocking @(posedge clock); endclocking
	default disable iff (rst);

	// reset and fixed outputs
	a_reset_idle: assert property ($fell(rst) |-> vram_chip_enable_lo && char_write_strobe && attr_write_strobe && !refresh_addr_sel)
		else $error("vram not idle after reset");
	a_fixed_outs: assert property (vram_chip_enable_hi && plasma_font_sel)
		else $error("fixed select output low");

	// host writes
	a_write_gate: assert property (wstb |-> (char_write_strobe != attr_write_strobe) && refresh_addr_sel && !display_mem_select_n && !host_mem_select_n && !host_mem_write_n)
		else $error("write strobe without host write");
	a_char_route: assert property (!char_write_strobe |-> !host_addr_bit0 && char_data_oe && char_data_out == host_data_in)
		else $error("char write misrouted");
	a_attr_route: assert property (!attr_write_strobe |-> host_addr_bit0 && attr_data_oe && attr_data_out == host_data_in)
		else $error("attr write misrouted");
	a_strobe_pulse: assert property ($rose(wstb) |=> !wstb)
		else $error("write strobe longer than one cycle");

	// host reads and ready
	a_read_byte: assert property ($rose(host_data_oe) |-> host_data_out == (host_addr_bit0 ? $past(attr_data_in) : $past(char_data_in)))
		else $error("wrong read byte");
	a_ready_hold: assert property ($rose(hreq) |=> !host_ready_out)
		else $error("ready not held low");
	a_ready_bound: assert property ($rose(hreq) |-> ##[2:20] host_ready_out)
		else $error("host access never served");

	// refresh and video
	a_refresh_path: assert property (font_code_latch |-> !refresh_addr_sel && !$past(refresh_addr_sel) && !char_data_oe && !attr_data_oe)
		else $error("refresh fetch not on refresh path");
	a_video_map: assert property (!$past(rst) |-> {video_data, frame_sig, frame_pulse, line_pulse} == $past(timing_video_in[6:0]) && shift_clock == ($past(timing_video_in[7]) | $past(timing_video_in[8])))
		else $error("video outputs misplaced");

	c_char_write: cover property (!char_write_strobe);
	c_attr_write: cover property (!attr_write_strobe);
	c_host_read: cover property ($rose(host_data_oe));
	c_refresh: cover property (font_code_latch);
endmodule // video_ram_and_font_access_checker

bind video_ram_and_font_access video_ram_and_font_access_checker u_chk (.*);

/* File: sim/video_ram_and_font_access_tb.sv */
`timescale 1ns/10ps
// ****************************************
// vram access bench
// ****************************************
module video_ram_and_font_access_tb;
	logic clock, rst, refresh_req, font_change_in, display_select_in, panel_type_in, crt_video_clock;
	logic display_mem_select_n, host_mem_select_n, host_mem_write_n, host_mem_read_n;
	logic host_addr_bit0, host_addr_bit14, host_data_oe, host_ready_out;
	logic [4:0] host_addr_low, vram_low_addr;
	logic [7:0] host_data_in, host_data_out, refresh_upper_addr;
	logic [7:0] char_data_in, char_data_out, attr_data_in, attr_data_out;
	logic refresh_addr_sel, vram_chip_enable_lo, vram_chip_enable_hi, char_write_strobe;
	logic attr_write_strobe, char_data_oe, attr_data_oe, font_code_latch, plasma_font_sel;
	logic dot_style_sel, line_pulse, frame_pulse, frame_sig, shift_clock, we, dx;
	logic [3:0] raster_scan_in, raster_line_addr, video_data, s_axi_awaddr, s_axi_araddr, s_axi_wstrb, rs;
	logic [8:0] timing_video_in;
	logic [13:0] refresh_mem_addr, ma, cap_r;
	logic [31:0] s_axi_wdata, s_axi_rdata, d;
	logic [1:0] s_axi_bresp, s_axi_rresp, r, ctrl;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [15:0] seed, tv;
	logic [14:0] cap_w;
	logic [7:0] rd;
	logic [6:0] a;
	integer n_fail = 0, checks = 0, n_lat = 0, i, j, k;

	video_ram_and_font_access DUT (.*);
	host_bus_model host (.*);

	// system clock and unrelated crt dot clock
	initial begin
		clock = 1'h0;
		forever #25 clock = ~clock;
	end
	// odd start offset keeps its edges off every system clock edge, so no sampling race
	initial begin
		crt_video_clock = 1'h0;
		#1.01;
		forever #34.92 crt_video_clock = ~crt_video_clock;
	end

	function logic [15:0] lfsr(input logic [15:0] s);
		lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	function logic [13:0] exp_ref(input logic gr, input logic [13:0] m, input logic [3:0] q);
		exp_ref = gr ? {q[1], q[0], m[11:0]} : m;
	endfunction
	function logic exp_dot(input logic lcd, input logic fc, input logic a3);
		exp_dot = lcd ? (a3 ^ fc) : fc;
	endfunction
	function logic [7:0] exp_rd(input logic a0, input logic [7:0] c, input logic [7:0] t);
		exp_rd = a0 ? t : c;
	endfunction

	// timing generator stand-in and capture of fetch and write cycles
	always @(posedge clock) begin
		tv <= lfsr(tv);
		if (font_code_latch === 1'h1) begin
			n_lat <= n_lat + 1;
			cap_r <= {vram_chip_enable_lo, refresh_upper_addr, vram_low_addr};
		end
		if (!char_write_strobe || !attr_write_strobe)
			cap_w <= {char_write_strobe, vram_chip_enable_lo, vram_low_addr,
				char_write_strobe ? attr_data_out : char_data_out};
	end
	assign timing_video_in = tv[8:0];

	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task tally_and_finish;
		if (n_fail == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// axi4-lite master; each channel held until its own ready
	task axi_wr(input logic [3:0] ad, input logic [31:0] dt, output logic [1:0] rp);
		@(posedge clock);
		s_axi_awaddr <= ad;
		s_axi_wdata <= dt;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		do begin
			@(posedge clock);
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
		end while (s_axi_bvalid !== 1'h1);
		rp = s_axi_bresp;
		s_axi_bready <= 1'h0;
	endtask
	task axi_rd(input logic [3:0] ad, output logic [31:0] dt, output logic [1:0] rp);
		@(posedge clock);
		s_axi_araddr <= ad;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do begin
			@(posedge clock);
			if (s_axi_arready) s_axi_arvalid <= 1'h0;
		end while (s_axi_rvalid !== 1'h1);
		dt = s_axi_rdata;
		rp = s_axi_rresp;
		s_axi_rready <= 1'h0;
	endtask

	// one-cycle fetch request with address held afterwards
	task refresh(input logic [13:0] m, input logic [3:0] q);
		@(posedge clock);
		refresh_mem_addr <= m;
		raster_scan_in <= q;
		refresh_req <= 1'h1;
		@(posedge clock);
		refresh_req <= 1'h0;
	endtask

	// watchdog: the whole run needs under four hundred cycles
	initial begin
		repeat (20000) @(posedge clock);
		n_fail++;
		tally_and_finish;
	end

	initial begin
		seed = 16'h0010;
		tv = 16'h0010;
		rst = 1'h1;
		{refresh_req, font_change_in} = 2'h0;
		{display_select_in, panel_type_in} = 2'h3;
		refresh_mem_addr = 14'h0;
		raster_scan_in = 4'h0;
		{char_data_in, attr_data_in} = 16'h0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 40'h0;
		s_axi_wstrb = 4'hF;
		repeat (16) @(posedge clock);
		rst <= 1'h0;
		axi_rd(4'h0, d, r);
		chk("ctrl reset", d, 32'h2);
		axi_rd(4'hC, d, r);
		chk("unmapped rresp", r, 32'h2);
		axi_wr(4'hC, 32'h5A, r);
		chk("unmapped bresp", r, 32'h2);
		// refresh off, graphics, text
		for (i = 0; i < 3; i++) begin
			ctrl = (i == 0) ? 2'h0 : {1'h1, i[0]};
			axi_wr(4'h0, {30'h0, ctrl}, r);
			chk("ctrl bresp", r, 32'h0);
			axi_rd(4'h0, d, r);
			chk("ctrl readback", d, {30'h0, ctrl});
			for (k = 0; k < 4; k++) begin
				seed = lfsr(seed);
				ma = seed[13:0];
				char_data_in <= seed[7:0];
				seed = lfsr(seed);
				rs = seed[3:0];
				attr_data_in <= seed[15:8];
				font_change_in <= seed[4];
				display_select_in <= seed[5];
				j = n_lat;
				refresh(ma, rs);
				repeat (8) @(posedge clock);
				chk("latch count", n_lat - j, ctrl[1]);
				if (ctrl[1]) begin
					chk("refresh addr", cap_r, exp_ref(ctrl[0], ma, rs));
					chk("raster out", raster_line_addr, rs);
					dx = exp_dot(display_select_in, font_change_in, attr_data_in[3]);
					chk("dot style", dot_style_sel, dx);
					axi_rd(4'h8, d, r);
					chk("fetch", d[15:0], {attr_data_in, char_data_in});
					chk("fetch rresp", r, 32'h0);
					axi_rd(4'h4, d, r);
					chk("status", d[3:0], {dx, 1'h0, font_change_in, display_select_in});
				end
			end
		end
		// host traffic, some of it racing a refresh fetch
		for (k = 0; k < 24; k++) begin
			seed = lfsr(seed);
			we = seed[0];
			a = seed[7:1];
			fork
				host.access(we, a, seed[15:8], rd);
				if (k[1]) refresh(seed[13:0], 4'h0);
			join
			if (we)
				chk("host write", cap_w, {a[0], a[6], a[5:1], seed[15:8]});
			else
				chk("host read", rd, exp_rd(a[0], char_data_in, attr_data_in));
		end
		tally_and_finish;
	end
endmodule // video_ram_and_font_access_tb
